// *** hdl/keypad_port_map.vh ***
// register map, field positions, reset values and notes for the keypad port
// Functional notes
// RQ1 - the port has eight pins, each input or output, with one direction bit per pin.
// RQ2 - a direction bit of one releases the pin driver so the pin is an input.
// RQ3 - a direction bit of zero drives the pin from its output latch.
// RQ4 - every pin has a weak pull-up, all enabled together when the active-low pull-up control bit 7 of the options register is zero.
// RQ5 - a pin configured as output never has its pull-up on.
// RQ6 - after reset the options register is all ones, so the pull-ups are off.
// RQ7 - only upper pins 7 to 4 configured as inputs take part in change detection.
// RQ8 - the upper pin levels are latched on each port read and compared continuously with the live levels.
// RQ9 - the four mismatch signals are ORed to set the change flag, bit 0 of the interrupt control register.
// RQ10 - a set change flag raises the wake request out of sleep.
// RQ11 - any read or write of the port data register ends the mismatch, after which software clears the flag.
// RQ12 - while a mismatch persists the flag keeps being set, so a clear only holds once the mismatch is gone.
// RQ13 - a pin change in the very cycle of a port read may be missed, optionally reproduced here.
// RQ14 - software should not poll the port while relying on change detection, since each read re-latches the compare value.
// RQ15 - the direction register resets to all ones, every pin an input.
// RQ16 - port writes load the output latches, reads return the pin levels, and the latches keep their value over reset.
// RQ17 - the change interrupt reaches the core only when the flag and its enable bit are both set.
`ifndef KEYPAD_PORT_MAP_VH
`define KEYPAD_PORT_MAP_VH
// register word indices (printed offsets are indices, byte address is four times)
`define PIN_DATA_IDX 8'h06
`define INTERRUPT_CONTROL_IDX 8'h0B
`define GLOBAL_OPTIONS_IDX 8'h81
`define PIN_DIRECTION_IDX 8'h86
`define EVENT_STATUS_IDX 8'h90
`define EVENT_MASK_IDX 8'h91
// field positions
`define PULLUP_DISABLE_N_BIT 7
`define CHANGE_FLAG_BIT 0
`define CHANGE_IRQ_ENABLE_BIT 3
// reset values
`define GLOBAL_OPTIONS_RST 8'hFF
`define PIN_DIRECTION_RST 8'hFF
`define INTERRUPT_CONTROL_RST 8'h00
`define EVENT_MASK_RST 2'h0
`endif

// *** hdl/keypad_port.v ***
// eight-bit keypad port with change detection and avalon register slave
`timescale 1ns/10ps
`default_nettype none
`include "keypad_port_map.vh"
module keypad_port
#(
  parameter MODEL_MISSED_FLAG = 0
)
(
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire [9:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  input wire [7:0] pin_in,
  output wire [7:0] pin_out,
  output wire [7:0] pin_oe_n,
  output wire [7:0] pullup_en,
  output wire wake_request,
  output wire change_irq,
  output wire irq
);
  reg [7:0] pin_sync1;
  reg [7:0] pin_sync2;
  reg [7:0] out_latch;
  reg [7:0] pin_direction;
  reg [7:0] global_options;
  reg [7:0] interrupt_control;
  reg [3:0] latched_upper;
  reg [1:0] event_status;
  reg [1:0] event_mask;
  reg ack;
  reg [7:0] prev_pins;
  wire [7:0] idx;
  wire word_ok;
  wire req;
  wire rd;
  wire wr;
  wire hit_data;
  wire hit_intc;
  wire hit_opt;
  wire hit_dir;
  wire hit_stat;
  wire hit_mask;
  wire mapped;
  wire [3:0] mismatch;
  wire change_cond;
  wire pin_edge;
  wire data_access;
  wire missed;
  wire flag_set;
  // address decode, word aligned
  assign idx = avs_address[9:2];
  assign word_ok = (avs_address[1:0] == 2'h0);
  assign req = (avs_read | avs_write) & clk_en;
  assign rd = avs_read & ack & clk_en;
  assign wr = avs_write & ack & clk_en & avs_byteenable[0];
  assign hit_data = word_ok & (idx == `PIN_DATA_IDX);
  assign hit_intc = word_ok & (idx == `INTERRUPT_CONTROL_IDX);
  assign hit_opt = word_ok & (idx == `GLOBAL_OPTIONS_IDX);
  assign hit_dir = word_ok & (idx == `PIN_DIRECTION_IDX);
  assign hit_stat = word_ok & (idx == `EVENT_STATUS_IDX);
  assign hit_mask = word_ok & (idx == `EVENT_MASK_IDX);
  assign mapped = hit_data | hit_intc | hit_opt | hit_dir | hit_stat | hit_mask;
  // one wait cycle, then the answer
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  // pin drivers and pull-ups per bit
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : pin_ctl
      assign pin_out[g] = out_latch[g]; // [RQ3]
      assign pin_oe_n[g] = pin_direction[g]; // [RQ2] [RQ1]
      assign pullup_en[g] = ~global_options[`PULLUP_DISABLE_N_BIT] & pin_direction[g]; // [RQ4] [RQ5]
    end
  endgenerate
  // upper input pins against the copy taken at the last port read or write
  assign mismatch = (pin_sync2[7:4] ^ latched_upper) & pin_direction[7:4]; // [RQ7] [RQ8]
  assign change_cond = |mismatch; // [RQ9]
  assign data_access = (rd | wr) & hit_data;
  // pin change landing on a port access: the re-latch would hide it
  assign pin_edge = |(pin_sync2[7:4] ^ prev_pins[7:4]);
  assign missed = data_access & (|((pin_sync2[7:4] ^ prev_pins[7:4]) & pin_direction[7:4])); // [RQ13]
  // flag set by a lasting mismatch, or by an access-edge change unless the missed case is modelled
  assign flag_set = (change_cond & ~data_access) | (missed & (MODEL_MISSED_FLAG == 0)); // [RQ9] [RQ13]
  assign wake_request = interrupt_control[`CHANGE_FLAG_BIT]; // [RQ10]
  assign change_irq = interrupt_control[`CHANGE_FLAG_BIT] & interrupt_control[`CHANGE_IRQ_ENABLE_BIT]; // [RQ17]
  assign irq = |(event_status & event_mask);
  // two-stage pin synchroniser
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_sync1 <= 8'h00;
      pin_sync2 <= 8'h00;
      prev_pins <= 8'h00;
    end
    else if (clk_en)
    begin
      pin_sync1 <= pin_in;
      pin_sync2 <= pin_sync1;
      prev_pins <= pin_sync2;
    end
  end
  // output latches keep their value over reset
  always @(posedge clk)
  begin
    if (clk_en && wr && hit_data)
      out_latch <= avs_writedata[7:0]; // [RQ16]
  end
  // control registers and change flag
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      pin_direction <= `PIN_DIRECTION_RST; // [RQ15]
      global_options <= `GLOBAL_OPTIONS_RST; // [RQ6]
      interrupt_control <= `INTERRUPT_CONTROL_RST;
      latched_upper <= 4'h0;
      event_status <= 2'h0;
      event_mask <= `EVENT_MASK_RST;
      ack <= 1'b0;
    end
    else if (clk_en)
    begin
      ack <= req & ~ack;
      if (wr && hit_dir)
        pin_direction <= avs_writedata[7:0];
      if (wr && hit_opt)
        global_options <= avs_writedata[7:0];
      if (wr && hit_mask)
        event_mask <= avs_writedata[1:0];
      // port access re-latches the compare copy
      if (data_access)
        latched_upper <= pin_sync2[7:4]; // [RQ8] [RQ11] [RQ14]
      // mismatch set wins over software clear
      if (wr && hit_intc)
        interrupt_control <= avs_writedata[7:0];
      if (flag_set)
        interrupt_control[`CHANGE_FLAG_BIT] <= 1'b1; // [RQ9] [RQ12]
      // sticky events: bit0 change, bit1 pin edge; write one clears
      if (wr && hit_stat)
        event_status <= event_status & ~avs_writedata[1:0];
      if (flag_set)
        event_status[0] <= 1'b1;
      if (pin_edge)
        event_status[1] <= 1'b1;
    end
  end
  // read data and response
  always @(posedge clk)
  begin
    if (!resetn)
    begin
      avs_readdata <= 32'h00000000;
      avs_response <= 2'h0;
    end
    else if (clk_en && req && !ack)
    begin
      avs_response <= mapped ? 2'h0 : 2'h3;
      avs_readdata <= 32'h00000000;
      if (hit_data)
        avs_readdata[7:0] <= pin_sync2; // [RQ16]
      if (hit_intc)
        avs_readdata[7:0] <= interrupt_control;
      if (hit_opt)
        avs_readdata[7:0] <= global_options;
      if (hit_dir)
        avs_readdata[7:0] <= pin_direction;
      if (hit_stat)
        avs_readdata[1:0] <= event_status;
      if (hit_mask)
        avs_readdata[1:0] <= event_mask;
    end
  end
endmodule // keypad_port
`default_nettype wire

// *** tb/keypad_port_sva.sv ***
// assertions on pins, pull-ups, change flag and bus handshake of the keypad port
`timescale 1ns/10ps
`default_nettype none
module keypad_port_sva
(
  input wire clk,
  input wire resetn,
  input wire clk_en,
  input wire avs_read,
  input wire avs_write,
  input wire avs_waitrequest,
  input wire [7:0] pin_in,
  input wire [7:0] pin_oe_n,
  input wire [7:0] pullup_en,
  input wire wake_request,
  input wire change_irq
);
  default clocking cb @(posedge clk); endclocking
  // pull-up relations
  property p_pu_out; disable iff (!resetn) (pullup_en & ~pin_oe_n) == 8'h00; endproperty
  a_pu_out: assert property (p_pu_out) else $error("pull-up on a driven pin");
  property p_pu_all; disable iff (!resetn) pullup_en == 8'h00 || pullup_en == pin_oe_n; endproperty
  a_pu_all: assert property (p_pu_all) else $error("pull-ups not switched together");
  // state right after reset
  property p_rst_dir; disable iff (!resetn) $rose(resetn) && $past(clk_en) |-> pin_oe_n == 8'hFF; endproperty
  a_rst_dir: assert property (p_rst_dir) else $error("pins not inputs after reset");
  property p_rst_pu; disable iff (!resetn) $rose(resetn) && $past(clk_en) |-> pullup_en == 8'h00; endproperty
  a_rst_pu: assert property (p_rst_pu) else $error("pull-ups on after reset");
  // change flag and interrupt
  property p_irq; disable iff (!resetn) change_irq |-> wake_request; endproperty
  a_irq: assert property (p_irq) else $error("interrupt without flag");
  property p_flag;
    disable iff (!resetn) (clk_en && pin_oe_n[7:4] == 4'hF && !wake_request && $changed(pin_in[7:4]) && !avs_read
      && !avs_write) ##1 (clk_en && $stable(pin_in) && !avs_read && !avs_write) [*4] |-> wake_request;
  endproperty
  a_flag: assert property (p_flag) else $error("upper pin change did not set flag");
  property p_fall; disable iff (!resetn) $fell(wake_request) |-> $past(avs_write) || !$past(resetn); endproperty
  a_fall: assert property (p_fall) else $error("flag dropped without a write");
  // one wait cycle per request
  property p_wait; disable iff (!resetn) $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("bad wait cycle count");
endmodule // keypad_port_sva
bind keypad_port keypad_port_sva u_sva (.clk, .resetn, .clk_en, .avs_read, .avs_write, .avs_waitrequest, .pin_in,
  .pin_oe_n, .pullup_en, .wake_request, .change_irq);
`default_nettype wire

// *** tb/keypad_pins.sv ***
// keypad switches and pin wire levels seen by the port
`timescale 1ns/10ps
`default_nettype none
module keypad_pins
(
  input wire clk,
  input wire [7:0] pin_out,
  input wire [7:0] pin_oe_n,
  input wire [7:0] pullup_en,
  input wire [7:0] key_down,
  output logic [7:0] pin_in = 8'h00
);
  // driven, else pressed low, else pulled high, else floating and wandering
  always @(posedge clk)
    pin_in <= (~pin_oe_n & pin_out) | (pin_oe_n & ~key_down & (pullup_en | ~pin_in));
endmodule // keypad_pins
`default_nettype wire

// *** tb/tb.sv ***
// self-checking bench for the keypad port
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'h0, resetn = 1'h0, avs_read = 1'h0, avs_write = 1'h0, f;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h0, r = 32'h1B01;
  logic [7:0] key_down = 8'h00, d, v, q;
  logic [1:0] resp;
  wire [31:0] avs_readdata;
  wire [1:0] avs_response;
  wire [7:0] pin_in, pin_out, pin_oe_n, pullup_en;
  wire avs_waitrequest, wake_request, change_irq, irq;
  int err_total = 0, num_checks = 0;
  // 50 MHz clock
  always #10 clk = ~clk;
  keypad_port u_keypad_port (.clk, .resetn, .clk_en(1'h1), .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .avs_response, .pin_in, .pin_out, .pin_oe_n, .pullup_en,
    .wake_request, .change_irq, .irq);
  keypad_pins u_keypad_pins (.clk, .pin_out, .pin_oe_n, .pullup_en, .key_down, .pin_in);
  // random source and expected pin level
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [7:0] lvl(input logic [7:0] dir, input logic [7:0] dat, input logic [7:0] key);
    return (~dir & dat) | (dir & ~key);
  endfunction
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    avs_address <= {idx, 2'h0};
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, wd};
    @(posedge clk);
    while (avs_waitrequest !== 1'h0)
      @(posedge clk);
    q = avs_readdata[7:0];
    resp = avs_response;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge clk);
  endtask
  task automatic conclude;
    if (err_total == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // reset, register checks, then random key rounds
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    chk("oe_n_rst", pin_oe_n, 8'hFF);
    chk("pullup_rst", pullup_en, 8'h00);
    bus(0, 8'h81, 0);
    chk("options", q, 8'hFF);
    bus(0, 8'h20, 0);
    chk("unmapped", {resp, q}, 10'h300);
    bus(1, 8'h81, 8'h7F);
    bus(1, 8'h91, 8'h01);
    for (int i = 0; i < 12; i++)
    begin
      r = lfsr(r);
      d = r[7:0] | (i[0] ? 8'hF0 : 8'h00);
      v = r[15:8];
      key_down <= 8'h00;
      bus(1, 8'h86, d);
      bus(1, 8'h06, v);
      chk("pin_out", pin_out, v);
      chk("oe_n", pin_oe_n, d);
      chk("pullup_en", pullup_en, d);
      repeat (6) @(posedge clk);
      bus(0, 8'h06, 0);
      chk("pin_data", q, lvl(d, v, 8'h00));
      bus(1, 8'h0B, 8'h08);
      bus(1, 8'h90, 8'h03);
      key_down <= {r[19:16], 4'h0};
      repeat (6) @(posedge clk);
      f = |(r[19:16] & d[7:4]);
      bus(1, 8'h0B, 8'h08);
      bus(0, 8'h0B, 0);
      chk("flag_held", q, {7'h04, f});
      chk("wake", wake_request, f);
      chk("change_irq", change_irq, f);
      chk("irq", irq, f);
      bus(0, 8'h90, 0);
      chk("status", q, {6'h00, f, f});
      bus(0, 8'h06, 0);
      bus(1, 8'h0B, 8'h08);
      chk("flag_clear", wake_request, 1'h0);
    end
    conclude();
  end
  // watchdog against a hung handshake
  initial
  begin
    repeat (5000) @(posedge clk);
    err_total++;
    conclude();
  end
endmodule // tb
`default_nettype wire
